// [rtl/serdes_lane_control_regs.svh]
// offsets, field positions, reset values and timing for the serdes lane control block
`ifndef SERDES_LANE_CONTROL_REGS_SVH
`define SERDES_LANE_CONTROL_REGS_SVH

// register byte offsets inside the serdes window
`define SLC_OFS_CONTROL 8'h00
`define SLC_OFS_TX_LANE_A 8'h04
`define SLC_OFS_TX_LANE_B 8'h08
`define SLC_OFS_RX_LANE 8'h0C
`define SLC_OFS_RX_EQ_LANE 8'h10

// serdes_control fields
`define SLC_LANE_SEL_MSB 4
`define SLC_LANE_SEL_LSB 0
`define SLC_SLEEP_BIT 5
`define SLC_CONTROL_RESET 32'h0000_0010

// lane target select encodings
`define SLC_SEL_ALL 5'h10
`define SLC_LANE_COUNT 4

// per-lane register reset value
`define SLC_LANE_REG_RESET 32'h0000_0000

// lane power states
`define SLC_PSTATE_P0 2'h0
`define SLC_PSTATE_P2 2'h3

// serdes power-up and initialisation time
`define SLC_INIT_TIME_NS 1000
`define SLC_CLOCK_PERIOD_NS 10
`define SLC_INIT_CYCLES ((`SLC_INIT_TIME_NS + `SLC_CLOCK_PERIOD_NS - 1) / `SLC_CLOCK_PERIOD_NS)

`endif

// [rtl/slc_pkg.sv]
// types shared by the serdes lane control block
package slc_pkg;

  // one configuration access, write or read
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } slc_cfg_req_s;

  // the four lane control words of one lane: a, b, rx, rx equaliser
  typedef logic [3:0][31:0] slc_lane_regs_t;

  // all lanes of one serdes
  typedef slc_lane_regs_t [3:0] slc_lane_bank_t;

  typedef enum logic [3:0] {
    SLC_ST_RUN = 4'b0001,
    SLC_ST_SLEEP = 4'b0010,
    SLC_ST_INIT = 4'b0100,
    SLC_ST_TRAIN = 4'b1000
  } slc_power_e;

endpackage

// [rtl/slc_lane_bank.sv]
// per-lane transmit and receive control storage steered by the lane target select
`timescale 1ns/1ps
`include "serdes_lane_control_regs.svh"

module slc_lane_bank (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // write request
  input wire logic wr_en,
  input wire logic [1:0] reg_idx,
  input wire logic [4:0] lane_target_select,
  input wire logic [31:0] wdata,
  // lane settings and readback
  output slc_pkg::slc_lane_bank_t lane_ctrl,
  output slc_pkg::slc_lane_regs_t last_written
);

  ////////////////////////////////////////////////////////////////////////////
  // true when a write with this select lands on the given lane
  function automatic logic lane_hit(input logic [4:0] sel, input logic [1:0] lane);
    lane_hit = (sel == `SLC_SEL_ALL) || (sel == {3'h0, lane}); // R2 R3
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // readback copy: last value written, whatever lane took it
  slc_pkg::slc_lane_regs_t next_last_written;

  always_comb begin
    next_last_written = last_written;
    if (wr_en) begin
      next_last_written[reg_idx] = wdata; // R5
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      last_written <= {4{`SLC_LANE_REG_RESET}};
    end else begin
      last_written <= next_last_written;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lane storage; a reserved select updates no lane
  genvar g;
  generate
    for (g = 0; g < `SLC_LANE_COUNT; g++) begin : g_lane
      slc_pkg::slc_lane_regs_t next_lane;

      always_comb begin
        next_lane = lane_ctrl[g];
        if (wr_en && lane_hit(lane_target_select, 2'(g))) begin
          next_lane[reg_idx] = wdata; // R1 R2 R3
        end
      end

      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          lane_ctrl[g] <= {4{`SLC_LANE_REG_RESET}};
        end else begin
          lane_ctrl[g] <= next_lane;
        end
      end
    end
  endgenerate

endmodule

// [rtl/slc_serdes_control.sv]
// serdes control register with lane steering, sleep control and power sequencing
// Summary of operation
// R1 - bits 4:0 of serdes_control choose the lane that lane register writes update
// R2 - select 0x0 to 0x3 writes only the lane with that index
// R3 - select 0x10 writes every lane of the serdes at once
// R4 - software never programs other select codes; such lane writes are undefined
// R5 - lane register reads return last value written, independent of select
// R6 - sleep bit 5 set puts all lanes in P2 and powers down clock multiplier
// R7 - setting sleep bit sends every port link state machine to Detect at once
// R8 - clearing sleep bit powers up, initialises serdes, then link training starts
// R9 - sleep bit writes are ignored while serdes is already off for another reason
`timescale 1ns/1ps
`include "serdes_lane_control_regs.svh"

module slc_serdes_control (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // configuration access
  input slc_pkg::slc_cfg_req_s cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // serdes already powered down by its port being disabled
  input wire logic serdes_off_ext,
  // lane settings
  output slc_pkg::slc_lane_bank_t lane_ctrl,
  // power control
  output logic [3:0][1:0] lane_pstate,
  output logic clock_multiplier_unit_down,
  output logic ltssm_force_detect,
  output logic ltssm_start_training
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode: lane register index, or none
  function automatic logic lane_decode(input logic [7:0] addr, output logic [1:0] idx);
    lane_decode = 1'b1;
    idx = 2'h0;
    case (addr)
      `SLC_OFS_TX_LANE_A: idx = 2'h0;
      `SLC_OFS_TX_LANE_B: idx = 2'h1;
      `SLC_OFS_RX_LANE: idx = 2'h2;
      `SLC_OFS_RX_EQ_LANE: idx = 2'h3;
      default: lane_decode = 1'b0;
    endcase
  endfunction

  localparam int INIT_CYCLES = `SLC_INIT_CYCLES < 1 ? 1 : `SLC_INIT_CYCLES;

  logic [4:0] lane_target_select;
  logic serdes_sleep_control;
  logic lane_wr;
  logic [1:0] wr_idx;
  logic lane_rd;
  logic [1:0] rd_idx;
  slc_pkg::slc_lane_regs_t last_written;

  // decode first on every pass so that the index never holds a stale value
  always_comb begin
    lane_wr = lane_decode(cfg_req.addr, wr_idx);
    lane_wr = lane_wr && cfg_req.wr;
    lane_rd = lane_decode(cfg_req.addr, rd_idx);
  end

  ////////////////////////////////////////////////////////////////////////////
  // serdes_control register
  logic [4:0] next_lane_target_select;
  logic next_serdes_sleep_control;

  always_comb begin
    next_lane_target_select = lane_target_select;
    next_serdes_sleep_control = serdes_sleep_control;
    if (cfg_req.wr && cfg_req.addr == `SLC_OFS_CONTROL) begin
      next_lane_target_select = cfg_req.wdata[`SLC_LANE_SEL_MSB:`SLC_LANE_SEL_LSB]; // R1
      if (!serdes_off_ext) begin
        next_serdes_sleep_control = cfg_req.wdata[`SLC_SLEEP_BIT]; // R9
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lane_target_select <= 5'(`SLC_CONTROL_RESET);
      serdes_sleep_control <= 1'b0;
    end else begin
      lane_target_select <= next_lane_target_select;
      serdes_sleep_control <= next_serdes_sleep_control;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lane storage
  slc_lane_bank u_lane_bank (
    .clock(clock),
    .rst_b(rst_b),
    .wr_en(lane_wr),
    .reg_idx(wr_idx),
    .lane_target_select(lane_target_select),
    .wdata(cfg_req.wdata),
    .lane_ctrl(lane_ctrl),
    .last_written(last_written)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the request, unmapped reads zero
  logic [31:0] next_cfg_rdata;
  logic next_cfg_rvalid;

  always_comb begin
    next_cfg_rvalid = cfg_req.rd;
    next_cfg_rdata = 32'h0000_0000;
    if (cfg_req.rd) begin
      if (cfg_req.addr == `SLC_OFS_CONTROL) begin
        next_cfg_rdata[`SLC_LANE_SEL_MSB:`SLC_LANE_SEL_LSB] = lane_target_select;
        next_cfg_rdata[`SLC_SLEEP_BIT] = serdes_sleep_control;
      end else if (lane_rd) begin
        next_cfg_rdata = last_written[rd_idx]; // R5
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rdata <= next_cfg_rdata;
      cfg_rvalid <= next_cfg_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power sequencing
  slc_pkg::slc_power_e state;
  slc_pkg::slc_power_e next_state;
  logic [15:0] init_count;
  logic [15:0] next_init_count;
  logic [3:0][1:0] next_lane_pstate;
  logic next_cmu_down;
  logic next_force_detect;
  logic next_start_training;

  always_comb begin
    next_state = state;
    next_init_count = init_count;
    next_force_detect = 1'b0;
    next_start_training = 1'b0;
    case (state)
      slc_pkg::SLC_ST_RUN: begin
        if (next_serdes_sleep_control) begin
          next_state = slc_pkg::SLC_ST_SLEEP;
          next_force_detect = 1'b1; // R7
        end
      end
      slc_pkg::SLC_ST_SLEEP: begin
        if (!next_serdes_sleep_control) begin
          next_state = slc_pkg::SLC_ST_INIT; // R8
          next_init_count = 16'(INIT_CYCLES - 1);
        end
      end
      slc_pkg::SLC_ST_INIT: begin
        if (next_serdes_sleep_control) begin
          next_state = slc_pkg::SLC_ST_SLEEP;
          next_force_detect = 1'b1; // R7
        end else if (init_count == 16'h0000) begin
          next_state = slc_pkg::SLC_ST_TRAIN;
          next_start_training = 1'b1; // R8
        end else begin
          next_init_count = init_count - 16'h0001;
        end
      end
      slc_pkg::SLC_ST_TRAIN: begin
        if (next_serdes_sleep_control) begin
          next_state = slc_pkg::SLC_ST_SLEEP;
          next_force_detect = 1'b1; // R7
        end else begin
          next_state = slc_pkg::SLC_ST_RUN;
        end
      end
      default: next_state = slc_pkg::SLC_ST_RUN;
    endcase
    next_cmu_down = (next_state == slc_pkg::SLC_ST_SLEEP); // R6
    next_lane_pstate = next_cmu_down ? {4{`SLC_PSTATE_P2}} : {4{`SLC_PSTATE_P0}}; // R6
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= slc_pkg::SLC_ST_RUN;
      init_count <= 16'h0000;
      lane_pstate <= {4{`SLC_PSTATE_P0}};
      clock_multiplier_unit_down <= 1'b0;
      ltssm_force_detect <= 1'b0;
      ltssm_start_training <= 1'b0;
    end else begin
      state <= next_state;
      init_count <= next_init_count;
      lane_pstate <= next_lane_pstate;
      clock_multiplier_unit_down <= next_cmu_down;
      ltssm_force_detect <= next_force_detect;
      ltssm_start_training <= next_start_training;
    end
  end

endmodule

// [verification/slc_serdes_control_sva.sv]
// assertion checker for the serdes control register
`timescale 1ns/1ps
module slc_serdes_control_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // watched ports
  input slc_pkg::slc_cfg_req_s cfg_req,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic serdes_off_ext,
  input slc_pkg::slc_lane_bank_t lane_ctrl,
  input wire logic [3:0][1:0] lane_pstate,
  input wire logic clock_multiplier_unit_down,
  input wire logic ltssm_force_detect,
  input wire logic ltssm_start_training
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic ctl_wr;
  assign ctl_wr = cfg_req.wr && cfg_req.addr == 8'h00 && !serdes_off_ext;
  // one more than the cycles since the serdes last left sleep, holding at 0xFF; zero until the first sleep
  logic [7:0] wake_age;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wake_age <= 8'h00;
    end else if (clock_multiplier_unit_down) begin
      wake_age <= 8'h01;
    end else if (wake_age != 8'h00 && wake_age != 8'hFF) begin
      wake_age <= wake_age + 8'h01;
    end
  end
  property p_rd_ans; cfg_req.rd |=> cfg_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rv_drop; !cfg_req.rd |=> !cfg_rvalid; endproperty
  a_rv_drop: assert property (p_rv_drop) else $error("stray read valid");
  property p_rd_idle; !cfg_rvalid |-> cfg_rdata == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_sleep; ctl_wr && cfg_req.wdata[5] && !clock_multiplier_unit_down
    |=> clock_multiplier_unit_down && ltssm_force_detect; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry missed");
  property p_pst; lane_pstate == (clock_multiplier_unit_down ? 8'hFF : 8'h00); endproperty
  a_pst: assert property (p_pst) else $error("lane power state wrong");
  property p_det; ltssm_force_detect |=> !ltssm_force_detect; endproperty
  a_det: assert property (p_det) else $error("detect pulse too long");
  property p_wake; ctl_wr && !cfg_req.wdata[5] && clock_multiplier_unit_down
    |=> !clock_multiplier_unit_down; endproperty
  a_wake: assert property (p_wake) else $error("wake missed");
  property p_train; wake_age == 8'h65 |-> ltssm_start_training; endproperty
  a_train: assert property (p_train) else $error("training start late");
  property p_train_only; ltssm_start_training |-> wake_age == 8'h65; endproperty
  a_train_only: assert property (p_train_only) else $error("training start mistimed");
  property p_off; serdes_off_ext && cfg_req.wr && cfg_req.addr == 8'h00
    |=> $stable(clock_multiplier_unit_down) && !ltssm_force_detect; endproperty
  a_off: assert property (p_off) else $error("sleep bit acted while off");
endmodule
bind slc_serdes_control slc_serdes_control_sva slc_serdes_control_sva_i (.clock, .rst_b,
  .cfg_req, .cfg_rdata, .cfg_rvalid, .serdes_off_ext, .lane_ctrl, .lane_pstate,
  .clock_multiplier_unit_down, .ltssm_force_detect, .ltssm_start_training);

// [verification/test_serdes_lane_control_register.sv]
// self-checking bench for the serdes control register
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h seen %h", n, e, a); end end
module test_serdes_lane_control_register;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  slc_pkg::slc_cfg_req_s cfg_req = '0;
  logic serdes_off_ext = 1'b0;
  logic [31:0] cfg_rdata;
  logic cfg_rvalid;
  slc_pkg::slc_lane_bank_t lane_ctrl;
  slc_pkg::slc_lane_bank_t exp_bank;
  logic [3:0][1:0] lane_pstate;
  logic cmu_down;
  logic force_detect;
  logic start_training;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  always #5 clock = ~clock;
  slc_serdes_control slc_serdes_control_i (.clock, .rst_b, .cfg_req, .cfg_rdata, .cfg_rvalid,
    .serdes_off_ext, .lane_ctrl, .lane_pstate, .clock_multiplier_unit_down(cmu_down),
    .ltssm_force_detect(force_detect), .ltssm_start_training(start_training));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge clock);
    cfg_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clock);
    cfg_req = '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    access(1'b0, a, 32'h0000_0000);
    `CHK("rvalid", 1'b1, cfg_rvalid)
    `CHK("rdata", e, cfg_rdata)
  endtask
  task automatic report_and_stop;
    $display("counts: %0d checked, %0d mismatches", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst_b = 1'b1;
    exp_bank = '0;
    rd_chk(8'h00, 32'h0000_0010);
    `CHK("reset lanes", exp_bank, lane_ctrl)
    $display("test reset done");
    access(1'b1, 8'h04, 32'hA5A5_0001);
    for (int l = 0; l < 4; l++) exp_bank[l][0] = 32'hA5A5_0001;
    `CHK("all lanes", exp_bank, lane_ctrl)
    for (int l = 0; l < 4; l++) begin
      access(1'b1, 8'h00, 32'(l));
      for (int r = 0; r < 4; r++) begin
        exp_bank[l][r] = 32'h1000_0000 + 32'(l * 16 + r);
        access(1'b1, 8'(4 + 4 * r), exp_bank[l][r]);
      end
    end
    `CHK("single lanes", exp_bank, lane_ctrl)
    for (int r = 0; r < 4; r++) rd_chk(8'(4 + 4 * r), exp_bank[3][r]);
    rd_chk(8'h40, 32'h0000_0000);
    $display("test lane steering done");
    access(1'b1, 8'h00, 32'h0000_0030);
    `CHK("cmu down", 1'b1, cmu_down)
    `CHK("pstate", 8'hFF, lane_pstate)
    `CHK("detect", 1'b1, force_detect)
    rd_chk(8'h00, 32'h0000_0030);
    access(1'b1, 8'h00, 32'h0000_0010);
    `CHK("cmu up", 1'b0, cmu_down)
    `CHK("pstate up", 8'h00, lane_pstate)
    repeat (99) @(negedge clock);
    `CHK("train early", 1'b0, start_training)
    @(negedge clock);
    `CHK("train", 1'b1, start_training)
    $display("test power done");
    serdes_off_ext = 1'b1;
    access(1'b1, 8'h00, 32'h0000_0023);
    `CHK("off cmu", 1'b0, cmu_down)
    `CHK("off detect", 1'b0, force_detect)
    rd_chk(8'h00, 32'h0000_0003);
    serdes_off_ext = 1'b0;
    $display("test external off done");
    report_and_stop();
  end
endmodule
